// ### core/trm_pkg.sv
// Constants, register map and carrier types of the receive status monitor.
package trm_pkg;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int MS_CYC = CLK_HZ / 1000;
  localparam int BLUE_US = 250;
  localparam int BLUE_CYC = BLUE_US * (CLK_HZ / 1_000_000);
  localparam int YEL_SET_MS = 600;
  localparam int YEL_CLR_MS = 200;
  localparam int VIOL_MIN_MS = 96;
  localparam int DEB_MS = 8;
  // ----------------------------------------------------------------------
  // Line framing and detector thresholds
  // ----------------------------------------------------------------------
  localparam logic [7:0] FRAME_LAST = 8'd192;
  localparam logic [7:0] TICK_RISE = 8'd130;
  localparam logic [7:0] TICK_FALL = 8'd33;
  localparam logic [7:0] ZERO_RUN = 8'd128;
  localparam logic [8:0] WIN_LAST = 9'd385;
  localparam logic [8:0] ONES_MIN = 9'd48;
  localparam logic [4:0] YEL_TOL = 5'd2;
  localparam logic [15:0] EXT_PATTERN = 16'h00FF;
  localparam logic [4:0] EXT_PERIOD = 5'd16;
  localparam int CHANNELS = 24;
  // ----------------------------------------------------------------------
  // Register map and field positions
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT1_OFS = 8'h04;
  localparam logic [7:0] STAT2_OFS = 8'h08;
  localparam logic [7:0] PHASE_OFS = 8'h0C;
  localparam logic [7:0] SIGSEL_OFS = 8'h10;
  localparam logic [7:0] SIGDAT_OFS = 8'h14;
  localparam logic [7:0] LINE_OFS = 8'h18;
  localparam int CTRL_ESF_BIT = 0;
  localparam int CTRL_DEB_BIT = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [4:0] SIGSEL_RST = 5'h00;
  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic phase_wrap_bit;
    logic [4:0] phase_slot_field;
    logic [2:0] phase_bitpos_field;
  } trm_phase_t;
  typedef struct packed {
    logic t256;
    logic t128;
    logic t64;
  } trm_viol_t;
endpackage

// ### core/trm_monitor.sv
// Receive status monitor of a T1 framer with an APB register slave.
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module trm_monitor
  import trm_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC,
  parameter int BLUE_CYCLES = BLUE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic recovered_line_clock_i,
  input wire logic line_pos_i,
  input wire logic line_neg_i,
  input wire logic backplane_bit_clock_i,
  input wire logic backplane_frame_pulse_b_i,
  input wire logic frame_start_i,
  input wire logic in_sync_i,
  input wire logic alias_seen_i,
  input wire logic resync_i,
  input wire logic fdl_valid_i,
  input wire logic fdl_bit_i,
  input wire logic sig_valid_i,
  input wire logic [4:0] sig_chan_i,
  input wire logic [3:0] sig_abcd_i,
  output logic no_input_flag_o,
  output logic recv_unipolar_pos_o,
  output logic recv_unipolar_neg_o,
  output logic recovered_frame_tick_o
);
  // ----------------------------------------------------------------------
  // Pin synchronisers and edge strobes
  // ----------------------------------------------------------------------
  logic [1:0] lclk_s_ff, pos_s_ff, neg_s_ff, bclk_s_ff, fp_s_ff;
  logic lclk_d_ff, bclk_d_ff;
  logic bit_stb, bp_stb;

  // Stage one feeds stage two only; edges are taken from stage two on.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lclk_s_ff <= 2'b00;
      pos_s_ff <= 2'b00;
      neg_s_ff <= 2'b00;
      bclk_s_ff <= 2'b00;
      fp_s_ff <= 2'b11;
      lclk_d_ff <= 1'b0;
      bclk_d_ff <= 1'b0;
    end else begin
      lclk_s_ff <= {lclk_s_ff[0], recovered_line_clock_i};
      pos_s_ff <= {pos_s_ff[0], line_pos_i};
      neg_s_ff <= {neg_s_ff[0], line_neg_i};
      bclk_s_ff <= {bclk_s_ff[0], backplane_bit_clock_i};
      fp_s_ff <= {fp_s_ff[0], backplane_frame_pulse_b_i};
      lclk_d_ff <= lclk_s_ff[1];
      bclk_d_ff <= bclk_s_ff[1];
    end
  end

  assign bit_stb = lclk_s_ff[1] & ~lclk_d_ff;
  assign bp_stb = bclk_s_ff[1] & ~bclk_d_ff;

  logic pos_b, neg_b, one_b;
  assign pos_b = pos_s_ff[1];
  assign neg_b = neg_s_ff[1];
  assign one_b = pos_b | neg_b;

  // ----------------------------------------------------------------------
  // Millisecond timebase
  // ----------------------------------------------------------------------
  logic [15:0] ms_cnt_ff;
  logic ms_tick;
  assign ms_tick = (ms_cnt_ff == 16'(MS_CYCLES - 1));

  // One shared tick keeps every long timer to a few bits.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) ms_cnt_ff <= 16'h0000;
    else if (ms_tick) ms_cnt_ff <= 16'h0000;
    else ms_cnt_ff <= ms_cnt_ff + 16'h0001;
  end

  // ----------------------------------------------------------------------
  // Registers written by software
  // ----------------------------------------------------------------------
  logic [7:0] ctrl_ff;
  logic [4:0] sigsel_ff;
  logic esf_mode, deb_en;
  logic apb_wr;
  assign esf_mode = ctrl_ff[CTRL_ESF_BIT];
  assign deb_en = ctrl_ff[CTRL_DEB_BIT];
  assign pready_o = psel_i & penable_i;
  assign apb_wr = pready_o & pwrite_i;

  // Writes land on the access edge; unmapped writes are dropped.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_ff <= CTRL_RST;
      sigsel_ff <= SIGSEL_RST;
    end else if (apb_wr) begin
      if (paddr_i == CTRL_OFS) ctrl_ff <= pwdata_i[7:0];
      else if (paddr_i == SIGSEL_OFS) sigsel_ff <= pwdata_i[4:0];
    end
  end

  // ----------------------------------------------------------------------
  // Line frame position and recovered tick
  // ----------------------------------------------------------------------
  logic [7:0] fbit_ff;
  logic tick_ff, frame_end, b2_slot;
  logic [7:0] fbit_m1;
  assign frame_end = bit_stb & (fbit_ff == FRAME_LAST);
  assign fbit_m1 = fbit_ff - 8'd1;
  assign b2_slot = (fbit_ff != 8'd0) & (fbit_m1[2:0] == 3'd1);

  // Divide by 193, re-aligned by the framer's frame start.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) fbit_ff <= 8'h00;
    else if (bit_stb) begin
      if (frame_start_i) fbit_ff <= 8'h01;
      else if (fbit_ff == FRAME_LAST) fbit_ff <= 8'h00;
      else fbit_ff <= fbit_ff + 8'h01;
    end
  end

  // Rising edge lands on bit 2 of channel 17, about half period high.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) tick_ff <= 1'b0;
    else if (bit_stb) begin
      if (fbit_ff == TICK_RISE) tick_ff <= 1'b1;
      else if (fbit_ff == TICK_FALL) tick_ff <= 1'b0;
    end
  end
  assign recovered_frame_tick_o = tick_ff;

  // ----------------------------------------------------------------------
  // No-input detection
  // ----------------------------------------------------------------------
  logic [7:0] zrun_ff;
  logic [8:0] win_ff, ones_ff;
  logic noin_ff, upos_ff, uneg_ff;

  // Fixed back-to-back windows; cheaper than a 386-bit sliding sum.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      zrun_ff <= 8'h00;
      win_ff <= 9'h000;
      ones_ff <= 9'h000;
      noin_ff <= 1'b0;
    end else if (bit_stb) begin
      if (one_b) zrun_ff <= 8'h00;
      else if (zrun_ff != ZERO_RUN) zrun_ff <= zrun_ff + 8'h01;
      if (win_ff == WIN_LAST) begin
        win_ff <= 9'h000;
        ones_ff <= 9'h000;
      end else begin
        win_ff <= win_ff + 9'h001;
        if (one_b && ones_ff != ONES_MIN) ones_ff <= ones_ff + 9'h001;
      end
      if (!one_b && zrun_ff == ZERO_RUN - 8'd1) noin_ff <= 1'b1;
      else if (win_ff == WIN_LAST && ones_ff == ONES_MIN)
        noin_ff <= 1'b0;
    end
  end

  // Unipolar copies are forced high while no input is seen.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      upos_ff <= 1'b0;
      uneg_ff <= 1'b0;
    end else begin
      upos_ff <= pos_b | noin_ff;
      uneg_ff <= neg_b | noin_ff;
    end
  end
  assign no_input_flag_o = noin_ff;
  assign recv_unipolar_pos_o = upos_ff;
  assign recv_unipolar_neg_o = uneg_ff;

  // ----------------------------------------------------------------------
  // D3/D4 remote warning
  // ----------------------------------------------------------------------
  logic [4:0] b2one_ff;
  logic qual_ff, warn_d4_ff;
  logic [9:0] zms_ff, cms_ff;

  // A frame with a couple of stray ones still counts, so errors pass.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      b2one_ff <= 5'h00;
      qual_ff <= 1'b0;
    end else if (frame_end) begin
      qual_ff <= (b2one_ff <= YEL_TOL);
      b2one_ff <= 5'h00;
    end else if (bit_stb && b2_slot && one_b && b2one_ff != 5'h1F) begin
      b2one_ff <= b2one_ff + 5'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      zms_ff <= 10'h000;
      cms_ff <= 10'h000;
      warn_d4_ff <= 1'b0;
    end else if (esf_mode) begin
      zms_ff <= 10'h000;
      cms_ff <= 10'h000;
      warn_d4_ff <= 1'b0;
    end else if (ms_tick) begin
      if (qual_ff) begin
        cms_ff <= 10'h000;
        if (zms_ff != 10'(YEL_SET_MS)) zms_ff <= zms_ff + 10'h001;
        if (zms_ff == 10'(YEL_SET_MS - 1)) warn_d4_ff <= 1'b1;
      end else begin
        zms_ff <= 10'h000;
        if (cms_ff != 10'(YEL_CLR_MS)) cms_ff <= cms_ff + 10'h001;
        if (cms_ff == 10'(YEL_CLR_MS - 1)) warn_d4_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // ESF remote warning
  // ----------------------------------------------------------------------
  logic [15:0] fdl_sr_ff;
  logic [4:0] since_ff;
  logic warn_ext_ff;
  logic [15:0] fdl_nxt;
  assign fdl_nxt = {fdl_sr_ff[14:0], fdl_bit_i};

  // The pattern must recur every 16 bits or the warning drops.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fdl_sr_ff <= 16'hFFFF;
      since_ff <= 5'h00;
      warn_ext_ff <= 1'b0;
    end else if (!esf_mode) begin
      warn_ext_ff <= 1'b0;
      since_ff <= 5'h00;
    end else if (fdl_valid_i) begin
      fdl_sr_ff <= fdl_nxt;
      if (fdl_nxt == EXT_PATTERN) begin
        warn_ext_ff <= 1'b1;
        since_ff <= 5'h00;
      end else if (since_ff == EXT_PERIOD - 5'd1) begin
        warn_ext_ff <= 1'b0;
      end else begin
        since_ff <= since_ff + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Alias flag and all-ones alarm
  // ----------------------------------------------------------------------
  logic alias_ff, blue_ff, zseen_ff;
  logic [8:0] orun_ff;
  logic [13:0] bcnt_ff;
  logic bwin_end;
  assign bwin_end = (bcnt_ff == 14'(BLUE_CYCLES - 1));

  // A new alias report wins over a resync in the same cycle.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) alias_ff <= 1'b0;
    else if (alias_seen_i) alias_ff <= 1'b1;
    else if (resync_i) alias_ff <= 1'b0;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      orun_ff <= 9'h000;
      bcnt_ff <= 14'h0000;
      zseen_ff <= 1'b0;
      blue_ff <= 1'b0;
    end else begin
      bcnt_ff <= bwin_end ? 14'h0000 : bcnt_ff + 14'h0001;
      if (bit_stb) begin
        if (!one_b) orun_ff <= 9'h000;
        else if (orun_ff != WIN_LAST + 9'd1) orun_ff <= orun_ff + 9'h001;
      end
      if (bwin_end) zseen_ff <= 1'b0;
      else if (bit_stb && !one_b) zseen_ff <= 1'b1;
      if (orun_ff == WIN_LAST + 9'd1 && !in_sync_i) blue_ff <= 1'b1;
      else if (bwin_end && zseen_ff) blue_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Bipolar violation toggles
  // ----------------------------------------------------------------------
  logic last_pos_ff, viol;
  logic [7:0] v256_ff;
  logic [6:0] v128_ff, vms_ff;
  logic pend_ff, vint_ok;
  trm_viol_t vt_ff;
  assign viol = bit_stb & one_b & (pos_b == last_pos_ff);
  assign vint_ok = (vms_ff == 7'(VIOL_MIN_MS));

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) last_pos_ff <= 1'b0;
    else if (bit_stb && one_b) last_pos_ff <= pos_b;
  end

  // Once 256 is reached, counting stops until the interval has run out.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      v256_ff <= 8'h00;
      v128_ff <= 7'h00;
      vms_ff <= 7'h00;
      pend_ff <= 1'b0;
      vt_ff <= '0;
    end else begin
      if (ms_tick && !vint_ok) vms_ff <= vms_ff + 7'h01;
      if (viol) v128_ff <= v128_ff + 7'h01;
      if (viol && v128_ff == 7'h7F) vt_ff.t128 <= ~vt_ff.t128;
      if (viol && v128_ff[5:0] == 6'h3F) vt_ff.t64 <= ~vt_ff.t64;
      if (pend_ff) begin
        if (vint_ok) begin
          vt_ff.t256 <= ~vt_ff.t256;
          pend_ff <= 1'b0;
          vms_ff <= 7'h00;
        end
      end else if (viol) begin
        v256_ff <= v256_ff + 8'h01;
        if (v256_ff == 8'hFF) begin
          if (vint_ok) begin
            vt_ff.t256 <= ~vt_ff.t256;
            vms_ff <= 7'h00;
          end else begin
            pend_ff <= 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Backplane position and phase capture
  // ----------------------------------------------------------------------
  logic [7:0] bp_cnt_ff, dphase;
  trm_phase_t phase_ff;
  logic tick_d_ff, tick_rise, fwrap;
  logic [7:0] old_ph;
  assign tick_rise = tick_ff & ~tick_d_ff;
  assign old_ph = {phase_ff.phase_slot_field, phase_ff.phase_bitpos_field};
  assign dphase = bp_cnt_ff - old_ph;
  // Shortest way round decides direction, then a wrap is a crossing of 0.
  assign fwrap = dphase[7] ? (bp_cnt_ff > old_ph) : (bp_cnt_ff < old_ph);

  // The frame pulse, active low, restarts the count at a bit clock edge.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) bp_cnt_ff <= 8'h00;
    else if (bp_stb) begin
      if (!fp_s_ff[1]) bp_cnt_ff <= 8'h00;
      else bp_cnt_ff <= bp_cnt_ff + 8'h01;
    end
  end

  // Faster line input moves the tick earlier, so the reading falls.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_d_ff <= 1'b0;
      phase_ff <= '0;
    end else begin
      tick_d_ff <= tick_ff;
      if (tick_rise) begin
        phase_ff.phase_slot_field <= bp_cnt_ff[7:3];
        phase_ff.phase_bitpos_field <= bp_cnt_ff[2:0];
        if (fwrap) phase_ff.phase_wrap_bit <= ~phase_ff.phase_wrap_bit;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Signalling store with freeze and debounce
  // ----------------------------------------------------------------------
  logic [3:0] store_ff [CHANNELS];
  logic [3:0] cand_ff [CHANNELS];
  logic [3:0] age_ff [CHANNELS];
  logic sig_take;
  assign sig_take = sig_valid_i & in_sync_i & (sig_chan_i < 5'(CHANNELS));

  // Out of sync nothing is stored, which freezes the last good values.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < CHANNELS; i++) begin
        store_ff[i] <= 4'h0;
        cand_ff[i] <= 4'h0;
        age_ff[i] <= 4'h0;
      end
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (sig_take && sig_chan_i == 5'(i)) begin
          cand_ff[i] <= sig_abcd_i;
          if (sig_abcd_i != cand_ff[i]) age_ff[i] <= 4'h0;
          if (!deb_en) store_ff[i] <= sig_abcd_i;
        end else if (ms_tick && in_sync_i) begin
          if (age_ff[i] != 4'(DEB_MS)) age_ff[i] <= age_ff[i] + 4'h1;
          else if (deb_en) store_ff[i] <= cand_ff[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------------
  logic [31:0] rd_val;
  logic rd_err;
  logic [3:0] sig_rd;
  // D3/D4 has only A and B; C and D read as zero there.
  assign sig_rd = esf_mode ? store_ff[sigsel_ff] :
                  {store_ff[sigsel_ff][3:2], 2'b00};

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    if (paddr_i == CTRL_OFS) rd_val = {24'h0, ctrl_ff};
    else if (paddr_i == STAT1_OFS)
      rd_val = {24'h0, warn_d4_ff, alias_ff, 1'b0, warn_ext_ff, 1'b0,
                vt_ff.t256, 2'b00};
    else if (paddr_i == STAT2_OFS)
      rd_val = {24'h0, blue_ff, phase_ff.phase_wrap_bit, 1'b0,
                vt_ff.t128, vt_ff.t64, 3'b000};
    else if (paddr_i == PHASE_OFS) rd_val = {24'h0, old_ph};
    else if (paddr_i == SIGSEL_OFS) rd_val = {27'h0, sigsel_ff};
    else if (paddr_i == SIGDAT_OFS) rd_val = {28'h0, sig_rd};
    else if (paddr_i == LINE_OFS) rd_val = {31'h0, noin_ff};
    else rd_err = 1'b1;
  end

  // Read data is registered in the setup cycle, so no wait state.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (psel_i && !penable_i) begin
      prdata_o <= pwrite_i ? 32'h0000_0000 : rd_val;
      pslverr_o <= rd_err;
    end
  end
endmodule // trm_monitor
`default_nettype wire

// ### core/trm_tick_note.sv
// Spare design file; every piece of logic sits in the monitor module.

// ### test/trm_monitor_asserts.sv
// Bus and line-output assertions for the receive status monitor.
`timescale 1ns/1ns
`default_nettype none
module trm_monitor_chk
  import trm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic no_input_flag_o,
  input wire logic recv_unipolar_pos_o,
  input wire logic recv_unipolar_neg_o
);
  // ----------------------------------------------------------------------
  // Setup decode; the bench only issues word-aligned addresses.
  // ----------------------------------------------------------------------
  logic setup;
  logic mapped;
  assign setup = psel_i && !penable_i;
  assign mapped = paddr_i <= LINE_OFS;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_ready_access: assert property (psel_i && penable_i |-> pready_o)
    else $error("Ready missing in access phase.");
  a_ready_idle: assert property (!penable_i |-> !pready_o)
    else $error("Ready outside access phase.");
  a_err_unmapped: assert property (setup && !mapped |=> pslverr_o)
    else $error("No error for unmapped address.");
  a_data_unmapped: assert property (setup && !mapped |=> prdata_o == 32'h0)
    else $error("Unmapped read data not zero.");
  a_err_mapped: assert property (setup && mapped |=> !pslverr_o)
    else $error("Error for mapped address.");
  a_upper_zero: assert property (setup && mapped |=> prdata_o[31:8] == 24'h0)
    else $error("Upper read bits not zero.");
  a_line_read: assert property (setup && paddr_i == LINE_OFS |=>
    prdata_o[0] == $past(no_input_flag_o)) else $error("Flag read wrong.");
  a_flag_forces: assert property (no_input_flag_o |=>
    recv_unipolar_pos_o && recv_unipolar_neg_o)
    else $error("Unipolar outputs low while no input.");
endmodule // trm_monitor_chk
bind trm_monitor trm_monitor_chk u_chk (.clk_i, .rst_b_i, .psel_i,
  .penable_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .no_input_flag_o,
  .recv_unipolar_pos_o, .recv_unipolar_neg_o);
`default_nettype wire

// ### test/trm_far_end.sv
// Far-end line source and backplane timing model.
`timescale 1ns/1ns
`default_nettype none
module trm_far_end (
  input wire logic clk_i,
  output logic line_clk_o = 1'b0,
  output logic pos_o = 1'b0,
  output logic neg_o = 1'b0,
  output logic frame_start_o = 1'b0,
  output logic bp_clk_o = 1'b0,
  output logic bp_fp_b_o = 1'b1
);
  int mode = 0;
  int bits_left = 0;
  logic last = 1'b0;
  logic pol;
  logic [4:0] lc = 5'h00;
  logic [4:0] bc = 5'h00;
  logic [7:0] bit_no = 8'h00;
  logic [7:0] bp_no = 8'h00;
  // Mode 0 spaces, 1 alternate marks, 2 repeated-polarity marks; it persists.
  task automatic send(input int m, input int n);
    mode = m;
    bits_left = n;
    wait (bits_left == 0);
  endtask
  // Data changes a cycle before the line clock falls, well clear of strobe.
  always @(posedge clk_i) begin
    lc <= lc + 5'h01;
    line_clk_o <= ~lc[4];
    if (lc == 5'h0F) begin
      pol = (mode == 1) ? ~last : last;
      pos_o <= (mode != 0) && pol;
      neg_o <= (mode != 0) && !pol;
      if (mode != 0) last <= pol;
      if (bits_left > 0) bits_left <= bits_left - 1;
      bit_no <= (bit_no == 8'd192) ? 8'h00 : bit_no + 8'h01;
      frame_start_o <= (bit_no == 8'd192);
    end
    // The block has no transmit clock pin, so the bit clock stands alone.
    bc <= (bc == 5'd23) ? 5'h00 : bc + 5'h01;
    bp_clk_o <= (bc < 5'd12);
    if (bc == 5'd23) bp_no <= bp_no + 8'h01;
    bp_fp_b_o <= (bp_no != 8'hFF);
  end
endmodule // trm_far_end
`default_nettype wire

// ### test/trm_monitor_tb.sv
// Self-checking bench of the receive status monitor.
`timescale 1ns/1ns
`default_nettype none
module trm_monitor_tb;
  import trm_pkg::*;
  logic clk_i = 1'b0, rst_b_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
  logic pwrite_i = 1'b0, in_sync_i = 1'b0, alias_seen_i = 1'b0;
  logic resync_i = 1'b0, fdl_valid_i = 1'b0, fdl_bit_i = 1'b0;
  logic sig_valid_i = 1'b0, pready_o, pslverr_o, e, no_input_flag_o;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, q;
  logic [4:0] sig_chan_i = 5'h00;
  logic [3:0] sig_abcd_i = 4'h0;
  logic recovered_line_clock_i, line_pos_i, line_neg_i, frame_start_i;
  logic backplane_bit_clock_i, backplane_frame_pulse_b_i;
  logic recv_unipolar_pos_o, recv_unipolar_neg_o, recovered_frame_tick_o;
  int bad_count = 0, checks_done = 0, cyc = 0;
  time fs_t = 0, gap = 0, t0 = 0;
  logic [7:0] ph = 8'h00;
  trm_monitor #(.MS_CYCLES(50), .BLUE_CYCLES(40)) u_trm_monitor (.clk_i,
    .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .recovered_line_clock_i, .line_pos_i, .line_neg_i,
    .backplane_bit_clock_i, .backplane_frame_pulse_b_i, .frame_start_i,
    .in_sync_i, .alias_seen_i, .resync_i, .fdl_valid_i, .fdl_bit_i,
    .sig_valid_i, .sig_chan_i, .sig_abcd_i, .no_input_flag_o,
    .recv_unipolar_pos_o, .recv_unipolar_neg_o, .recovered_frame_tick_o);
  trm_far_end u_far (.clk_i, .line_clk_o(recovered_line_clock_i),
    .pos_o(line_pos_i), .neg_o(line_neg_i), .frame_start_o(frame_start_i),
    .bp_clk_o(backplane_bit_clock_i), .bp_fp_b_o(backplane_frame_pulse_b_i));
  // ----------------------------------------------------------------------
  // Clock, hang guard and tick timing against the far-end frame start.
  // ----------------------------------------------------------------------
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      bad_count++;
      results();
    end
  end
  always @(posedge frame_start_i) fs_t = $time;
  always @(posedge recovered_frame_tick_o) gap = $time - fs_t;
  // ----------------------------------------------------------------------
  // Tasks: compare, bus access, strobes.
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Holds the request until ready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, x);
    apb(1'b0, a, 32'h0);
    check(q & m, x);
  endtask
  task automatic fdl(input logic [15:0] p);
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk_i);
      fdl_valid_i <= 1'b1;
      fdl_bit_i <= p[i];
      @(posedge clk_i);
      fdl_valid_i <= 1'b0;
    end
  endtask
  task automatic sig(input logic [4:0] c, input logic [3:0] v);
    @(posedge clk_i);
    sig_valid_i <= 1'b1;
    sig_chan_i <= c;
    sig_abcd_i <= v;
    @(posedge clk_i);
    sig_valid_i <= 1'b0;
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(CTRL_OFS, 32'hFFFFFFFF, 32'h0);
    rd(SIGSEL_OFS, 32'hFFFFFFFF, 32'h0);
    rd(8'h1C, 32'hFFFFFFFF, 32'h0);
    check({31'h0, e}, 32'h1);
    apb(1'b1, CTRL_OFS, 32'h81);
    rd(CTRL_OFS, 32'hFFFFFFFF, 32'h81);
    u_far.send(1, 800);
    rd(LINE_OFS, 32'h1, 32'h0);
    rd(STAT2_OFS, 32'h80, 32'h80);
    check(32'(gap / 640), 32'd130);
    u_far.send(0, 127);
    u_far.send(1, 2);
    rd(LINE_OFS, 32'h1, 32'h0);
    rd(STAT2_OFS, 32'h80, 32'h0);
    u_far.send(0, 130);
    rd(LINE_OFS, 32'h1, 32'h1);
    check({30'h0, recv_unipolar_pos_o, recv_unipolar_neg_o}, 32'h3);
    u_far.send(2, 64);
    u_far.send(1, 2);
    rd(STAT2_OFS, 32'h18, 32'h08);
    u_far.send(2, 64);
    u_far.send(1, 2);
    rd(STAT2_OFS, 32'h18, 32'h10);
    u_far.send(2, 128);
    u_far.send(1, 2);
    rd(STAT2_OFS, 32'h18, 32'h00);
    rd(STAT1_OFS, 32'h04, 32'h04);
    // Line frames run 32 cycles longer than backplane frames: +4 per 3.
    @(posedge recovered_frame_tick_o) t0 = $time;
    apb(1'b0, PHASE_OFS, 32'h0);
    ph = q[7:0];
    repeat (3) @(posedge recovered_frame_tick_o);
    check(32'($time - t0), 32'd370560);
    apb(1'b0, PHASE_OFS, 32'h0);
    check({24'h0, q[7:0] - ph}, 32'h4);
    rd(LINE_OFS, 32'h1, 32'h0);
    alias_seen_i <= 1'b1;
    @(posedge clk_i) alias_seen_i <= 1'b0;
    rd(STAT1_OFS, 32'h40, 32'h40);
    resync_i <= 1'b1;
    @(posedge clk_i) resync_i <= 1'b0;
    rd(STAT1_OFS, 32'h40, 32'h00);
    fdl(16'h00FF);
    rd(STAT1_OFS, 32'h10, 32'h10);
    fdl(16'h0000);
    rd(STAT1_OFS, 32'h10, 32'h00);
    apb(1'b1, CTRL_OFS, 32'h01);
    in_sync_i <= 1'b1;
    sig(5'd5, 4'hF);
    apb(1'b1, SIGSEL_OFS, 32'h5);
    rd(SIGDAT_OFS, 32'hF, 32'hF);
    in_sync_i <= 1'b0;
    sig(5'd5, 4'h3);
    rd(SIGDAT_OFS, 32'hF, 32'hF);
    apb(1'b1, CTRL_OFS, 32'h00);
    in_sync_i <= 1'b1;
    sig(5'd6, 4'hF);
    apb(1'b1, SIGSEL_OFS, 32'h6);
    rd(SIGDAT_OFS, 32'hF, 32'hC);
    apb(1'b1, CTRL_OFS, 32'h80);
    sig(5'd6, 4'h4);
    rd(SIGDAT_OFS, 32'hF, 32'hC);
    repeat (500) @(posedge clk_i);
    rd(SIGDAT_OFS, 32'hF, 32'h4);
    results();
  end
endmodule // trm_monitor_tb
`default_nettype wire
